// ==== hw/rsp_pkg.sv ====
// rsp_pkg: constants and carrier types for the serial slave port
// assumes: included before every design file of the port
package rsp_pkg;
    // ========================================
    // address map of the register side
    localparam logic [6:0] RSP_CLK_LO   = 7'h00;  // first clock register
    localparam logic [6:0] RSP_CLK_HI   = 7'h1F;  // last clock register
    localparam logic [6:0] RSP_RAM_LO   = 7'h20;  // first user memory byte
    localparam logic [6:0] RSP_RAM_HI   = 7'h7F;  // last user memory byte
    localparam logic [6:0] RSP_ALM0_LO  = 7'h07;  // first alarm-0 register
    localparam logic [6:0] RSP_ALM0_HI  = 7'h0A;  // last alarm-0 register
    // ========================================
    // framing and reset values
    localparam int         RSP_BYTE_BITS = 8;     // bits in a group
    localparam logic [2:0] RSP_BIT_LAST  = 3'h7;  // index of last bit of a group
    localparam logic [2:0] RSP_BIT_RST   = 3'h0;  // bit counter after reset
    localparam logic [7:0] RSP_BYTE_RST  = 8'h00; // shift register after reset
    localparam int         RSP_BUF_DEPTH = 2;     // entries in the write buffer
    localparam int         RSP_SYNC_LEN  = 2;     // synchroniser stages

    // ========================================
    // one written byte on its way to the register side
    typedef struct packed {
        logic [6:0] addr; // target location
        logic [7:0] data; // byte written
    } rsp_wr_t;

    // frame phase
    typedef enum logic [2:0] {
        RSP_IDLE = 3'b001,  // no frame
        RSP_ADDR = 3'b010,  // receiving address byte
        RSP_DATA = 3'b100   // data bytes of the burst
    } rsp_state_t;
endpackage : rsp_pkg

// ==== hw/rsp_wr_buffer.sv ====
// rsp_wr_buffer: two-entry valid/ready buffer for written bytes
// assumes: one clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module rsp_wr_buffer
    import rsp_pkg::*;
#(
    parameter int DEPTH = RSP_BUF_DEPTH  // entries, power of two
) (
    input  wire logic    clock,
    input  wire logic    sys_rst,
    input  wire rsp_wr_t inData,
    input  wire logic    inValid,
    output logic         inReady,
    output rsp_wr_t      outData,
    output logic         outValid,
    input  wire logic    outReady
);
    localparam int AW = $clog2(DEPTH);

    // elaboration check: pointer math needs a power of two
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
        $error("rsp_wr_buffer: DEPTH must be a power of two >= 2");
    end

    // ========================================
    // storage and pointers, one extra bit tells full from empty
    rsp_wr_t          mem_q [DEPTH];  // entries
    logic    [AW:0]   wrPtr_q;        // write pointer
    logic    [AW:0]   rdPtr_q;        // read pointer
    wire logic        pushEn = inValid && inReady;
    wire logic        popEn  = outValid && outReady;

    assign inReady  = (wrPtr_q - rdPtr_q) != (AW + 1)'(DEPTH); // honest full
    assign outValid = wrPtr_q != rdPtr_q;                      // honest empty
    assign outData  = mem_q[rdPtr_q[AW-1:0]];

    // ========================================
    // pointer update
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else begin
            if (pushEn) wrPtr_q <= wrPtr_q + 1'b1;
            if (popEn)  rdPtr_q <= rdPtr_q + 1'b1;
        end
    end

    // entries need no reset, valid covers them
    always_ff @(posedge clock) begin
        if (pushEn) mem_q[wrPtr_q[AW-1:0]] <= inData;
    end

    AST_BUF_NO_OVERFLOW: assert property (@(posedge clock) disable iff (sys_rst)
        !inReady |-> !outValid == 1'b0)
        else $error("buffer full while empty");
endmodule : rsp_wr_buffer
`default_nettype wire

// ==== hw/rtc_serial_port.sv ====
// rtc_serial_port: serial slave port of a real-time clock
// assumes: all pins are asynchronous to clock and are synchronised here;
// the register side answers reads combinationally from rdAddr
`timescale 1ns/1ps
`default_nettype none

module rtc_serial_port
    import rsp_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic       interface_select_strap, // high: four-wire
    input  wire logic       serialClkPin,           // serial clock from master
    input  wire logic       chipEnablePin,          // transfer select, active high
    input  wire logic       serial_in_pin,          // data in (also shared line in)
    output logic            serial_out_pin,         // data out / shared line out
    output logic            serialOutEn,            // high while driving data out
    output logic [6:0]      rdAddr,                 // location being read
    input  wire logic [7:0] rdData,                 // byte at rdAddr
    output logic            rdStrobe,               // read data taken
    output rsp_wr_t         wrWord,                 // byte to store
    output logic            wrValid,                // wrWord valid
    input  wire logic       wrReady,                // register side accepts
    output logic            alarm0ClearPulse        // clear alarm0_match_flag
);
    // ========================================
    // pin synchronisers, stage one read by stage two only
    logic [1:0] sclkSync_q;   // serial clock
    logic [1:0] ceSync_q;     // transfer select
    logic [1:0] dinSync_q;    // data in
    logic [1:0] modeSync_q;   // strap
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sclkSync_q <= 2'h0;
            ceSync_q   <= 2'h0;
            dinSync_q  <= 2'h0;
            modeSync_q <= 2'h0;
        end else begin
            sclkSync_q <= {sclkSync_q[0], serialClkPin};
            ceSync_q   <= {ceSync_q[0], chipEnablePin};
            dinSync_q  <= {dinSync_q[0], serial_in_pin};
            modeSync_q <= {modeSync_q[0], interface_select_strap};
        end
    end

    // delayed copies for edge finding
    logic sclkPrev_q;   // last synced clock level
    logic cePrev_q;     // last synced select level
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sclkPrev_q <= 1'b0;
            cePrev_q   <= 1'b0;
        end else begin
            sclkPrev_q <= sclkSync_q[1];
            cePrev_q   <= ceSync_q[1];
        end
    end

    // ========================================
    // decode of edges and mode
    wire logic sclkNow  = sclkSync_q[1];
    wire logic ceNow    = ceSync_q[1];
    wire logic dinNow   = dinSync_q[1];
    wire logic sclkRise = sclkNow && !sclkPrev_q;
    wire logic sclkFall = !sclkNow && sclkPrev_q;
    wire logic ceRise   = ceNow && !cePrev_q;    // frame starts
    wire logic ceFall   = !ceNow && cePrev_q;    // frame ends

    // mode and polarity, latched at frame start only
    logic spiMode_q;   // 1 four-wire, 0 three-wire
    logic idlePol_q;   // clock level at select rise
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            spiMode_q <= 1'b1;
            idlePol_q <= 1'b0;
        end else if (ceRise) begin
            spiMode_q <= modeSync_q[1];
            idlePol_q <= sclkNow;
        end
    end

    // strobe edge returns to idle level in four-wire mode; three-wire rises
    // (four-wire modes 1 and 3: shift on leave, latch on return)
    wire logic leaveIdle = idlePol_q ? sclkFall : sclkRise;
    wire logic backIdle  = idlePol_q ? sclkRise : sclkFall;
    wire logic active    = ceNow && !ceRise;
    wire logic strobeEv  = active && (spiMode_q ? backIdle : sclkRise);
    wire logic shiftEv   = active && (spiMode_q ? leaveIdle : sclkFall);

    // ========================================
    // frame state and byte assembly
    rsp_state_t state_q;      // frame phase
    logic [2:0] bitCnt_q;     // bits received in group
    logic [7:0] rxShift_q;    // incoming bits
    logic [7:0] txShift_q;    // outgoing bits
    logic [6:0] ptr_q;        // address pointer
    logic       isWrite_q;    // direction of the burst

    // incoming bit placed by order: MSB first or LSB first
    wire logic [7:0] rxNext   = spiMode_q ? {rxShift_q[6:0], dinNow}
                                          : {dinNow, rxShift_q[7:1]};
    wire logic       byteDone = strobeEv && (bitCnt_q == RSP_BIT_LAST);
    wire logic [6:0] addrIn   = rxNext[6:0];
    wire logic       dirIn    = rxNext[7];

    // wrap inside the current space
    wire logic       inClk    = ptr_q <= RSP_CLK_HI;
    wire logic [6:0] ptrInc   = (inClk && ptr_q == RSP_CLK_HI) ? RSP_CLK_LO
                              : (ptr_q == RSP_RAM_HI) ? RSP_RAM_LO
                              : ptr_q + 7'h01;
    wire logic       hitAlm0  = addrIn >= RSP_ALM0_LO && addrIn <= RSP_ALM0_HI;
    wire logic       hitAlmInc = ptrInc >= RSP_ALM0_LO && ptrInc <= RSP_ALM0_HI;

    // write bytes leave through the buffer; a byte pushed into a full buffer
    // is dropped, since pushWr does not wait for bufInReady
    rsp_wr_t    bufIn;
    logic       bufInReady;
    logic       pushWr;
    assign bufIn  = '{addr: ptr_q, data: rxNext};
    assign pushWr = byteDone && state_q == RSP_DATA && isWrite_q;

    // frame state machine
    always_ff @(posedge clock) begin
        if (sys_rst || ceFall || !ceNow) begin
            state_q  <= RSP_IDLE;
            bitCnt_q <= RSP_BIT_RST;
        end else begin
            unique case (state_q)
                RSP_IDLE: begin
                    if (ceRise) state_q <= RSP_ADDR;
                    bitCnt_q <= RSP_BIT_RST;
                end
                RSP_ADDR: begin
                    if (strobeEv) bitCnt_q <= bitCnt_q + 3'h1;
                    if (byteDone) state_q <= RSP_DATA;
                end
                RSP_DATA: begin
                    if (strobeEv) bitCnt_q <= bitCnt_q + 3'h1;
                end
                default: state_q <= RSP_IDLE;
            endcase
        end
    end

    // receive shifter
    always_ff @(posedge clock) begin
        if (sys_rst || !ceNow) rxShift_q <= RSP_BYTE_RST;
        else if (strobeEv)     rxShift_q <= rxNext;
    end

    // pointer and direction
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ptr_q     <= RSP_CLK_LO;
            isWrite_q <= 1'b0;
        end else if (byteDone && state_q == RSP_ADDR) begin
            ptr_q     <= addrIn;
            isWrite_q <= dirIn;
        end else if (byteDone && state_q == RSP_DATA) begin
            ptr_q     <= ptrInc;
        end
    end

    // alarm-0 flag clear whenever pointer lands in that group
    always_ff @(posedge clock) begin
        if (sys_rst) alarm0ClearPulse <= 1'b0;
        else alarm0ClearPulse <= byteDone && ((state_q == RSP_ADDR && hitAlm0)
                                 || (state_q == RSP_DATA && hitAlmInc));
    end

    // ========================================
    // read path: load on the shift edge that opens each byte
    wire logic readPhase = state_q == RSP_DATA && !isWrite_q;
    wire logic loadTx    = readPhase && shiftEv && bitCnt_q == RSP_BIT_RST;
    wire logic [7:0] txNext = spiMode_q ? {txShift_q[6:0], 1'b0} : {1'b0, txShift_q[7:1]};

    // readPhase alone gates shifting; the enable follows it
    always_ff @(posedge clock) begin
        if (sys_rst || !ceNow) begin
            txShift_q <= RSP_BYTE_RST;
        end else if (loadTx) begin
            txShift_q <= rdData;
        end else if (readPhase && shiftEv) begin
            txShift_q <= txNext;
        end
    end

    // bit on the line: first bit of a loaded byte comes from rdData
    wire logic [7:0] txSrc = loadTx ? rdData : txNext;
    wire logic       txBit = spiMode_q ? txSrc[7] : txSrc[0];

    // output pin and its enable, registered
    always_ff @(posedge clock) begin
        if (sys_rst || !ceNow) begin
            serial_out_pin <= 1'b0;
            serialOutEn    <= 1'b0;
        end else if (readPhase && shiftEv) begin
            serial_out_pin <= txBit;
            serialOutEn    <= 1'b1;
        end else if (!readPhase) begin
            serialOutEn    <= 1'b0;
        end
    end

    // read address and strobe to register side
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rdAddr   <= RSP_CLK_LO;
            rdStrobe <= 1'b0;
        end else begin
            rdAddr   <= (byteDone && state_q == RSP_ADDR) ? addrIn
                      : (byteDone && state_q == RSP_DATA) ? ptrInc : ptr_q;
            rdStrobe <= loadTx;
        end
    end

    // ========================================
    // write buffer toward register side
    rsp_wr_t bufOut;
    logic    bufOutValid;
    rsp_wr_buffer #(.DEPTH(RSP_BUF_DEPTH)) u_buf (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .inData   (bufIn),
        .inValid  (pushWr),
        .inReady  (bufInReady),
        .outData  (bufOut),
        .outValid (bufOutValid),
        .outReady (wrReady && !wrValid)
    );

    // output register stage so outputs come from flops
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wrValid <= 1'b0;
            wrWord  <= '0;
        end else if (!wrValid && bufOutValid && wrReady) begin
            wrValid <= 1'b1;
            wrWord  <= bufOut;
        end else if (wrValid && wrReady) begin
            wrValid <= 1'b0;
        end
    end

    // ========================================
    // checks
    sequence s_addrDone;
        state_q == RSP_ADDR && byteDone;
    endsequence

    sequence s_dataByte;
        state_q == RSP_DATA && byteDone;
    endsequence

    // pointer away from both top locations
    sequence s_noWrap;
        ptr_q != RSP_CLK_HI && ptr_q != RSP_RAM_HI;
    endsequence

    // data byte whose step lands inside the alarm-0 group
    sequence s_almStep;
        s_dataByte ##0 hitAlmInc;
    endsequence

    AST_MODE_LATCH: assert property (@(posedge clock) disable iff (sys_rst)
        ceRise |=> spiMode_q == $past(modeSync_q[1]))
        else $error("mode not latched at frame start");
    AST_POL_LATCH: assert property (@(posedge clock) disable iff (sys_rst)
        ceRise |=> idlePol_q == $past(sclkNow))
        else $error("polarity not latched");
    AST_ADDR_FIRST: assert property (@(posedge clock) disable iff (sys_rst)
        s_addrDone |=> state_q == RSP_DATA && ptr_q == $past(addrIn))
        else $error("address byte not taken");
    AST_DIR: assert property (@(posedge clock) disable iff (sys_rst)
        s_addrDone |=> isWrite_q == $past(rxNext[7]))
        else $error("direction bit wrong");
    AST_WRAP_CLK: assert property (@(posedge clock) disable iff (sys_rst)
        byteDone && state_q == RSP_DATA && ptr_q == RSP_CLK_HI |=> ptr_q == RSP_CLK_LO)
        else $error("clock space did not wrap");
    AST_WRAP_RAM: assert property (@(posedge clock) disable iff (sys_rst)
        byteDone && state_q == RSP_DATA && ptr_q == RSP_RAM_HI |=> ptr_q == RSP_RAM_LO)
        else $error("memory space did not wrap");
    AST_RELEASE: assert property (@(posedge clock) disable iff (sys_rst)
        (!ceNow || isWrite_q) |=> !serialOutEn)
        else $error("output driven outside read");
    AST_ABORT: assert property (@(posedge clock) disable iff (sys_rst)
        ceFall |=> state_q == RSP_IDLE && bitCnt_q == RSP_BIT_RST)
        else $error("frame not aborted");
    AST_ALM0: assert property (@(posedge clock) disable iff (sys_rst)
        (s_addrDone and hitAlm0) |=> alarm0ClearPulse)
        else $error("alarm-0 clear missing");

    // ========================================
    // burst and handshake checks
    // plain step: pointer moves up by one
    AST_PTR_INC: assert property (@(posedge clock) disable iff (sys_rst)
        (s_dataByte and s_noWrap) |=> ptr_q == $past(ptr_q) + 7'h01)
        else $error("pointer did not step");
    // an increment into the group clears the flag too
    AST_ALM0_INC: assert property (@(posedge clock) disable iff (sys_rst)
        s_almStep |=> alarm0ClearPulse)
        else $error("alarm-0 clear missing after step");
    // a stall longer than two byte times would drop a write
    AST_WR_NO_DROP: assert property (@(posedge clock) disable iff (sys_rst)
        pushWr |-> bufInReady)
        else $error("write byte dropped at full buffer");
    // stalled buffer keeps its head word steady
    AST_BUF_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
        bufOutValid && !(wrReady && !wrValid) |=> bufOutValid && $stable(bufOut))
        else $error("buffered write changed while stalled");
    // a loaded read byte is already on the line
    AST_RD_DRIVE: assert property (@(posedge clock) disable iff (sys_rst)
        rdStrobe |-> serialOutEn)
        else $error("read strobe without output drive");
    // no read strobe or alarm-0 clear reaches the register side between frames
    AST_IDLE_QUIET: assert property (@(posedge clock) disable iff (sys_rst)
        !ceNow |=> !rdStrobe && !alarm0ClearPulse)
        else $error("activity outside a frame");
    // frame phase stays one-hot
    AST_ONEHOT: assert property (@(posedge clock) disable iff (sys_rst)
        $onehot(state_q))
        else $error("frame phase code illegal");
endmodule : rtc_serial_port
`default_nettype wire

// ==== bench/rsp_host_model.sv ====
// rsp_host_model: behavioural serial bus master facing the port's pins
// assumes: the bench sets the strap to match the mode handed to frame
`timescale 1ns/1ps
`default_nettype none
module rsp_host_model (
    output logic      serialClkPin,
    output logic      chipEnablePin,
    output logic      serial_in_pin,
    input  wire logic serial_out_pin,
    input  wire logic serialOutEn
);
    // ========================================
    // state of the master
    logic threeW;  // shared-line mode of this frame
    logic mstEn;   // master drives data
    logic mstBit;  // bit driven by the master
    logic relV;    // released line: changes on every link edge
    int   clashes; // both parties driving, or read data missing

    initial begin
        serialClkPin  = 1'b0;
        chipEnablePin = 1'b0;
        threeW        = 1'b0;
        mstEn         = 1'b0;
        mstBit        = 1'b0;
        relV          = 1'b0;
        clashes       = 0;
    end

    // no pull on the line, so a released line must not keep its old value
    always @(serialClkPin) relV = ~relV;

    // shared line: port output wins when enabled, else master, else floating
    assign serial_in_pin = (threeW && serialOutEn) ? serial_out_pin
                         : (mstEn ? mstBit : relV);

    // ========================================
    // bit helpers
    task automatic drive(input logic [63:0] tx, input int k, input int nb, input logic rd);
        logic [7:0] b;
        b      = tx[8*(k/8) +: 8];
        mstEn  = (k < nb) && (k < 8 || !rd);
        mstBit = threeW ? b[k%8] : b[7-k%8];
    endtask : drive

    task automatic sample(input int j, inout logic [63:0] rx);
        // read bits must come from an enabled output
        if (!serialOutEn) clashes++;
        rx[8*(j/8) + (threeW ? j%8 : 7-j%8)] = threeW ? serial_in_pin : serial_out_pin;
    endtask : sample

    // ========================================
    // one whole frame of nb clocks; rx byte 0 is the first data byte
    task automatic frame(input logic tw, input logic pol, input logic [63:0] tx,
                         input int nb, output logic [63:0] rx);
        int   k;
        logic rd;
        rx           = '0;
        rd           = !tx[7];
        threeW       = tw;
        serialClkPin = pol; // idle level before select
        #30;
        chipEnablePin = 1'b1;
        if (tw) drive(tx, 0, nb, rd);
        #60;
        for (k = 0; k < nb; k++) begin
            // four-wire: new bit on leaving idle, port latches on return
            if (!tw) drive(tx, k, nb, rd);
            serialClkPin = ~pol;
            #23;
            if (mstEn && serialOutEn) clashes++;
            if (tw && rd && k >= 8) sample(k - 8, rx);
            #1;
            serialClkPin = pol;
            if (tw) drive(tx, k + 1, nb, rd);
            #23;
            if (mstEn && serialOutEn) clashes++;
            if (!tw && rd && k >= 8) sample(k - 8, rx);
            #1;
        end
        mstEn = 1'b0;
        #30;
        chipEnablePin = 1'b0;
        #100;
    endtask : frame
endmodule : rsp_host_model
`default_nettype wire

// ==== bench/rtc_serial_port_test.sv ====
// rtc_serial_port_test: self-checking bench for the serial slave port
// assumes: host model drives the pins; this bench plays the register side
`timescale 1ns/1ps
`default_nettype none
module rtc_serial_port_test
    import rsp_pkg::*;
;
    // ========================================
    // clock, reset, register side
    logic            clock       = 1'b0;
    logic            sysRst      = 1'b1;
    logic            strap       = 1'b1; // high: four-wire
    logic            wrReady     = 1'b1;
    int              errCount    = 0;
    int              totalChecks = 0;
    int              almCnt      = 0;    // alarm clear pulses seen
    int              rdCnt       = 0;    // read strobes seen
    rsp_wr_t         wq[$];              // writes taken by register side
    wire logic       sclk, sel, sin, sout, soutEn, rdStrobe, wrValid, almClr;
    wire logic [6:0] rdAddr;
    wire logic [7:0] rdData;
    wire rsp_wr_t    wrWord;

    always #2.5 clock = ~clock;
    // register contents: a pattern unique to each location
    assign rdData = {1'b0, rdAddr} ^ 8'hA5;

    rtc_serial_port u_rtc_serial_port (.clock(clock), .sys_rst(sysRst),
        .interface_select_strap(strap), .serialClkPin(sclk), .chipEnablePin(sel),
        .serial_in_pin(sin), .serial_out_pin(sout), .serialOutEn(soutEn),
        .rdAddr(rdAddr), .rdData(rdData), .rdStrobe(rdStrobe), .wrWord(wrWord),
        .wrValid(wrValid), .wrReady(wrReady), .alarm0ClearPulse(almClr));
    rsp_host_model u_rsp_host_model (.serialClkPin(sclk), .chipEnablePin(sel),
        .serial_in_pin(sin), .serial_out_pin(sout), .serialOutEn(soutEn));

    // collect accepted writes and alarm clears
    always @(posedge clock) begin
        if (!sysRst && wrValid === 1'b1 && wrReady) wq.push_back(wrWord);
        if (almClr === 1'b1) almCnt++;
        if (rdStrobe === 1'b1) rdCnt++;
    end

    // ========================================
    // compare helpers
    task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
        totalChecks++;
        if (got !== exp) begin
            errCount++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chkByte

    task automatic chkWord(input rsp_wr_t got, input rsp_wr_t exp);
        totalChecks++;
        if (got !== exp) begin
            errCount++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chkWord

    task automatic chkCnt(input int got, input int exp);
        totalChecks++;
        if (got != exp) begin
            errCount++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chkCnt

    // expected pointer step, wrapping inside each space
    function automatic logic [6:0] nextA(input logic [6:0] a);
        if (a == RSP_CLK_HI) return RSP_CLK_LO;
        if (a == RSP_RAM_HI) return RSP_RAM_LO;
        return a + 7'h01;
    endfunction : nextA

    task automatic chkWrites(input logic [6:0] a0, input logic [63:0] d, input int n);
        rsp_wr_t e;
        int      i;
        chkCnt(wq.size(), n);
        e.addr = a0;
        for (i = 0; i < n && i < wq.size(); i++) begin
            e.data = d[8*i +: 8];
            chkWord(wq[i], e);
            e.addr = nextA(e.addr);
        end
        wq.delete();
    endtask : chkWrites

    task automatic chkReads(input logic [6:0] a0, input logic [63:0] rx, input int n);
        logic [6:0] a;
        int         i;
        a = a0;
        for (i = 0; i < n; i++) begin
            chkByte(rx[8*i +: 8], {1'b0, a} ^ 8'hA5);
            a = nextA(a);
        end
    endtask : chkReads

    task automatic setMode(input logic v);
        @(posedge clock) strap <= v;
        repeat (4) @(posedge clock);
        almCnt = 0;
        rdCnt  = 0;
        u_rsp_host_model.clashes = 0;
    endtask : setMode

    task automatic endTest(input string name);
        chkCnt(u_rsp_host_model.clashes, 0);
        $display("%s done", name);
    endtask : endTest

    // ========================================
    // scenarios
    task automatic testWrite4;
        logic [63:0] rx;
        setMode(1'b1);
        u_rsp_host_model.frame(1'b0, 1'b0, {8'h33, 8'h22, 8'h11, 8'h9E}, 32, rx);
        repeat (10) @(posedge clock);
        chkWrites(7'h1E, {8'h33, 8'h22, 8'h11}, 3);
        chkCnt(almCnt, 0);
        chkCnt(rdCnt, 0);
        endTest("four-wire write burst");
    endtask : testWrite4

    task automatic testRead4;
        logic [63:0] rx;
        setMode(1'b1);
        u_rsp_host_model.frame(1'b0, 1'b1, 64'h7E, 32, rx);
        repeat (10) @(posedge clock);
        chkReads(7'h7E, rx, 3);
        chkCnt(wq.size(), 0);
        chkCnt(rdCnt, 3);
        endTest("four-wire read burst");
    endtask : testRead4

    // receiver stalls through the frame; the buffer must keep both bytes
    task automatic testWrite3;
        logic [63:0] rx;
        setMode(1'b0);
        @(posedge clock) wrReady <= 1'b0;
        u_rsp_host_model.frame(1'b1, 1'b0, {8'hCD, 8'hAB, 8'h86}, 24, rx);
        repeat (10) @(posedge clock);
        chkCnt(wq.size(), 0);
        @(posedge clock) wrReady <= 1'b1;
        repeat (10) @(posedge clock);
        chkWrites(7'h06, {8'hCD, 8'hAB}, 2);
        // pointer steps onto 07h and then 08h, both in the alarm-0 group
        chkCnt(almCnt, 2);
        endTest("three-wire stalled write");
    endtask : testWrite3

    task automatic testRead3;
        logic [63:0] rx;
        setMode(1'b0);
        u_rsp_host_model.frame(1'b1, 1'b0, 64'h0A, 16, rx);
        repeat (10) @(posedge clock);
        chkReads(7'h0A, rx, 1);
        chkCnt(almCnt, 1);
        // the closing falling edge already loads the next byte
        chkCnt(rdCnt, 2);
        endTest("three-wire read");
    endtask : testRead3

    // a cut-off frame must leave no trace on the next one
    task automatic testAbort;
        logic [63:0] rx;
        setMode(1'b1);
        u_rsp_host_model.frame(1'b0, 1'b0, 64'hFF, 5, rx);
        u_rsp_host_model.frame(1'b0, 1'b0, {8'h5A, 8'hB0}, 16, rx);
        repeat (10) @(posedge clock);
        chkWrites(7'h30, 64'h5A, 1);
        chkCnt(almCnt, 0);
        endTest("aborted frame");
    endtask : testAbort

    // ========================================
    // run control
    task automatic summarize;
        $display("checks %0d mismatches %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (2) @(posedge clock);
        sysRst <= 1'b0;
        repeat (4) @(posedge clock);
        testWrite4();
        testRead4();
        testWrite3();
        testRead3();
        testAbort();
        summarize();
    end

    // tests need about 8 us; a hang is cut off well beyond that
    initial begin
        #100000;
        errCount++;
        summarize();
    end
endmodule : rtc_serial_port_test
`default_nettype wire
